// *** mevg_pkg.sv ***
// Constants shared by the monitor event gating register slice.
package mevg_pkg;
	// Channel counts.
	localparam int MEVG_NFAN = 4;
	localparam int MEVG_NPWM = 3;
	localparam int MEVG_NTEMP = 3;
	localparam int MEVG_NADC = 8;
	// Converter and reading widths.
	localparam int MEVG_ADC_BITS = 10;
	localparam int MEVG_AVG_BITS = 12;
	localparam int MEVG_READ_BITS = 8;
	localparam int MEVG_NIB = 4;
	localparam int MEVG_TACH_BITS = 16;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_FAN_EN = 8'h80;
	localparam logic [7:0] IDX_ASSOC = 8'h81;
	localparam logic [7:0] IDX_TEMP_EN = 8'h82;
	localparam logic [7:0] IDX_LOW_DIODES = 8'h85;
	localparam logic [7:0] IDX_LOW_12V_AMBIENT = 8'h86;
	localparam logic [7:0] IDX_LOW_5V_2V5 = 8'h87;
	localparam logic [7:0] IDX_LOW_VCC = 8'h88;
	localparam logic [7:0] IDX_TEST_A = 8'h89;
	localparam logic [7:0] IDX_TEST_B = 8'h8A;
	localparam logic [7:0] IDX_TEST_C = 8'h8B;
	localparam logic [7:0] IDX_CTRL = 8'hC0;
	localparam logic [7:0] IDX_STATUS = 8'hC1;
	localparam logic [7:0] IDX_MASK = 8'hC2;
	// Reset values and writable-bit masks.
	localparam logic [7:0] RST_FAN_EN = 8'h1E;
	localparam logic [7:0] RST_ASSOC = 8'hA4;
	localparam logic [7:0] RST_TEMP_EN = 8'h0E;
	localparam logic [7:0] RST_TEST_A = 8'h00;
	localparam logic [7:0] RST_TEST_B = 8'h4D;
	localparam logic [7:0] RST_TEST_C = 8'h4D;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] MASK_FAN_EN = 8'h1F;
	localparam logic [7:0] MASK_TEMP_EN = 8'h0F;
	localparam logic [7:0] MASK_TEST_C = 8'h7F;
	localparam logic [7:0] MASK_STATUS = 8'h7F;
	localparam logic [7:0] RD_ZERO = 8'h00;
	// Field positions.
	localparam int BIT_GROUP = 0;
	localparam int CTRL_LOCK = 0;
	localparam int CTRL_ALERT_EN = 2;
	localparam int CTRL_INIT = 7;
	localparam int ST_TACH = 0;
	localparam int ST_TEMP = 4;
	localparam int ASSOC_W = 2;
	// Encodings and limits.
	localparam logic [1:0] ASSOC_RSVD = 2'h3;
	localparam logic [15:0] TACH_NO_LIMIT = 16'hFFFF;
	localparam logic [7:0] DUTY_OFF = 8'h00;
	// Converter channel order: remote 1, remote 2, ambient, 12V,
	// 2.5V, 5V, Vccp, VCC; channel c sits in low-bits register c/2,
	// nibble c%2.
	localparam int CH_REMOTE1 = 0;
	localparam int CH_REMOTE2 = 1;
	localparam int CH_AMBIENT = 2;
endpackage

// *** mevg_regs.sv ***
// Event gating, tach association and low-bit latch registers.
`timescale 1ns/1ps
`default_nettype none
module mevg_regs
	import mevg_pkg::*;
#(
	parameter int NFAN = MEVG_NFAN,
	parameter int NPWM = MEVG_NPWM,
	parameter int NADC = MEVG_NADC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Hardware monitor readings, limits and read strobes.
	input wire logic [NADC-1:0][MEVG_AVG_BITS-1:0] adcReading,
	input wire logic [NADC-1:0] readingRead,
	input wire logic [MEVG_NTEMP-1:0][7:0] tempLowLimit,
	input wire logic [MEVG_NTEMP-1:0][7:0] tempHighLimit,
	// Fan tachometers and PWM state.
	input wire logic [NFAN-1:0][MEVG_TACH_BITS-1:0] tachReading,
	input wire logic [NFAN-1:0][MEVG_TACH_BITS-1:0] tachMinLimit,
	input wire logic [NPWM-1:0][7:0] pwmDuty,
	input wire logic [NPWM-1:0] pwmFanDisabled,
	// Interrupt outputs.
	output logic alertPinN,
	output logic irq
);

	logic [7:0] fanEn;
	logic [7:0] assoc;
	logic [7:0] tempEn;
	logic [7:0] testC;
	logic [7:0] ctrl;
	logic [7:0] status;
	logic [7:0] mask;
	logic [NADC/2-1:0][7:0] lowBits;
	logic softRst;
	logic wbReq;
	logic wbWr;
	logic [7:0] idx;
	logic [7:0] rdData;
	logic [7:0] wrByte;
	logic [7:0] next_status;
	logic [NFAN-1:0] tachDutyOff;
	logic [NFAN-1:0] tachFanOff;
	logic [NFAN-1:0] tachViol;
	logic [MEVG_NTEMP-1:0] tempViol;
	logic [7:0] evSet;
	logic next_alert;

	// Temperature event index: 0 ambient, 1 remote 1, 2 remote 2.
	function automatic int tempChan(input int t);
		int c;
		c = CH_REMOTE2;
		if (t == 0) begin
			c = CH_AMBIENT;
		end else if (t == 1) begin
			c = CH_REMOTE1;
		end
		return c;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	assign idx = wb_adr_i[9:2];
	assign wrByte = wb_dat_i[7:0];
	assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// A write lands at the edge where the master samples ack high.
	assign wbWr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
		wb_sel_i[0];

	// Every request is answered one cycle after it is seen.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wbReq;
			if (wbReq && !wb_we_i) begin
				wb_dat_o <= {24'h000000, rdData};
			end
		end
	end

	// The init bit pulses a soft reset that spares the latched low bits.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			softRst <= 1'b0;
		end else begin
			softRst <= wbWr && hit(idx, IDX_CTRL) && wrByte[CTRL_INIT];
		end
	end

	// Lock is sticky until reset; alert enable obeys the lock as well.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= RST_CTRL;
		end else if (softRst) begin
			ctrl <= RST_CTRL;
		end else if (wbWr && hit(idx, IDX_CTRL) && !ctrl[CTRL_LOCK]) begin
			ctrl[CTRL_LOCK] <= wrByte[CTRL_LOCK];
			ctrl[CTRL_ALERT_EN] <= wrByte[CTRL_ALERT_EN];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fanEn <= RST_FAN_EN;
			assoc <= RST_ASSOC;
			tempEn <= RST_TEMP_EN;
			testC <= RST_TEST_C;
		end else if (softRst) begin
			fanEn <= RST_FAN_EN;
			assoc <= RST_ASSOC;
			tempEn <= RST_TEMP_EN;
			testC <= RST_TEST_C;
		end else if (wbWr && !ctrl[CTRL_LOCK]) begin
			if (hit(idx, IDX_FAN_EN)) begin
				fanEn <= wrByte & MASK_FAN_EN;
			end
			if (hit(idx, IDX_ASSOC)) begin
				assoc <= wrByte;
			end
			if (hit(idx, IDX_TEMP_EN)) begin
				tempEn <= wrByte & MASK_TEMP_EN;
			end
			if (hit(idx, IDX_TEST_C)) begin
				testC <= wrByte & MASK_TEST_C;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mask <= RST_MASK;
		end else if (softRst) begin
			mask <= RST_MASK;
		end else if (wbWr && hit(idx, IDX_MASK)) begin
			mask <= wrByte & MASK_STATUS;
		end
	end

	// Tach gating and limit checks.
	always_comb begin
		logic [1:0] sel;
		sel = ASSOC_RSVD;
		for (int i = 0; i < NFAN; i++) begin
			sel = assoc[ASSOC_W*i +: ASSOC_W];
			tachDutyOff[i] = (sel == ASSOC_RSVD) ? 1'b1 :
				(pwmDuty[sel] == DUTY_OFF);
			tachFanOff[i] = (sel == ASSOC_RSVD) ? 1'b1 :
				pwmFanDisabled[sel];
			tachViol[i] = (tachMinLimit[i] != TACH_NO_LIMIT) &&
				(tachReading[i] > tachMinLimit[i]);
		end
	end

	always_comb begin
		logic [7:0] hiByte;
		hiByte = RD_ZERO;
		for (int t = 0; t < MEVG_NTEMP; t++) begin
			hiByte = adcReading[tempChan(t)][MEVG_AVG_BITS-1 -:
				MEVG_READ_BITS];
			tempViol[t] = ($signed(hiByte) < $signed(tempLowLimit[t])) ||
				($signed(hiByte) > $signed(tempHighLimit[t]));
		end
	end

	// A tach reading above its minimum count means the fan runs slow.
	always_comb begin
		evSet = RD_ZERO;
		for (int i = 0; i < NFAN; i++) begin
			evSet[ST_TACH+i] = tachViol[i] && fanEn[i+1] &&
				!tachDutyOff[i] && !tachFanOff[i];
		end
		for (int t = 0; t < MEVG_NTEMP; t++) begin
			evSet[ST_TEMP+t] = tempViol[t] && tempEn[t+1];
		end
	end

	// Setting wins over a write-one clear in the same cycle.
	always_comb begin
		next_status = status;
		if (wbWr && hit(idx, IDX_STATUS)) begin
			next_status = status & ~wrByte;
		end
		next_status = (next_status | evSet) & MASK_STATUS;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status <= RD_ZERO;
		end else if (softRst) begin
			status <= RD_ZERO;
		end else begin
			status <= next_status;
		end
	end

	always_comb begin
		next_alert = (fanEn[BIT_GROUP] &&
			|status[ST_TACH +: MEVG_NFAN]) ||
			(tempEn[BIT_GROUP] && |status[ST_TEMP +: MEVG_NTEMP]);
		next_alert = next_alert && ctrl[CTRL_ALERT_EN];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alertPinN <= 1'b1;
			irq <= 1'b0;
		end else begin
			alertPinN <= !next_alert;
			irq <= |(status & mask);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lowBits <= '0;
		end else begin
			for (int c = 0; c < NADC; c++) begin
				if (readingRead[c]) begin
					lowBits[c/2][MEVG_NIB*(c%2) +: MEVG_NIB] <=
						adcReading[c][MEVG_NIB-1:0];
				end
			end
		end
	end

	// Unmapped indices read as zero and still acknowledge.
	always_comb begin
		rdData = RD_ZERO;
		unique case (idx)
			IDX_FAN_EN: rdData = fanEn;
			IDX_ASSOC: rdData = assoc;
			IDX_TEMP_EN: rdData = tempEn;
			IDX_LOW_DIODES: rdData = lowBits[0];
			IDX_LOW_12V_AMBIENT: rdData = lowBits[1];
			IDX_LOW_5V_2V5: rdData = lowBits[2];
			IDX_LOW_VCC: rdData = lowBits[3];
			IDX_TEST_A: rdData = RST_TEST_A;
			IDX_TEST_B: rdData = RST_TEST_B;
			IDX_TEST_C: rdData = testC;
			IDX_CTRL: rdData = ctrl;
			IDX_STATUS: rdData = status;
			IDX_MASK: rdData = mask;
			default: rdData = RD_ZERO;
		endcase
	end

	property p_lock;
		@(posedge clk) disable iff (!rstn)
		(ctrl[CTRL_LOCK] && wbWr && hit(idx, IDX_ASSOC) && !softRst)
			|=> $stable(assoc);
	endproperty
	a_lock: assert property (p_lock)
		else $error("association changed while locked");

	property p_fan_group;
		@(posedge clk) disable iff (!rstn)
		(ctrl[CTRL_ALERT_EN] && fanEn[BIT_GROUP] && status[ST_TACH])
			|=> !alertPinN;
	endproperty
	a_fan_group: assert property (p_fan_group)
		else $error("fan event did not pull alert low");

	property p_tach_en;
		@(posedge clk) disable iff (!rstn)
		$rose(status[ST_TACH]) |-> $past(fanEn[1]);
	endproperty
	a_tach_en: assert property (p_tach_en)
		else $error("tach status set while disabled");

	property p_global;
		@(posedge clk) disable iff (!rstn)
		!ctrl[CTRL_ALERT_EN] |=> alertPinN;
	endproperty
	a_global: assert property (p_global)
		else $error("alert driven without global enable");

	property p_duty;
		@(posedge clk) disable iff (!rstn)
		$rose(status[ST_TACH]) |-> !$past(tachDutyOff[0]);
	endproperty
	a_duty: assert property (p_duty)
		else $error("tach status set at zero duty");

	property p_fan_off;
		@(posedge clk) disable iff (!rstn)
		$rose(status[ST_TACH+1]) |-> !$past(tachFanOff[1]);
	endproperty
	a_fan_off: assert property (p_fan_off)
		else $error("tach status set with fan disabled");

	property p_no_limit;
		@(posedge clk) disable iff (!rstn)
		(tachMinLimit[2] == TACH_NO_LIMIT && !status[ST_TACH+2])
			|=> !status[ST_TACH+2];
	endproperty
	a_no_limit: assert property (p_no_limit)
		else $error("tach status set with all-ones minimum");

	property p_temp_en;
		@(posedge clk) disable iff (!rstn)
		$rose(status[ST_TEMP]) |-> $past(tempEn[1]);
	endproperty
	a_temp_en: assert property (p_temp_en)
		else $error("ambient status set while disabled");

	property p_latch;
		@(posedge clk) disable iff (!rstn)
		readingRead[CH_AMBIENT] |=> lowBits[1][MEVG_NIB-1:0] ==
			$past(adcReading[CH_AMBIENT][MEVG_NIB-1:0]);
	endproperty
	a_latch: assert property (p_latch)
		else $error("ambient low bits not latched");

	property p_limit;
		@(posedge clk) disable iff (!rstn)
		(tempViol[0] && tempEn[1] && !softRst) |=> status[ST_TEMP];
	endproperty
	a_limit: assert property (p_limit)
		else $error("ambient violation not flagged");

	property p_ack;
		@(posedge clk) disable iff (!rstn)
		wbReq |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus answer not a one-cycle ack");

endmodule
`default_nettype wire

// *** tb_monitor_event_gating_regs.sv ***
// Self-checking testbench for the monitor event gating register slice.
`timescale 1ns/1ps
`default_nettype none
module tb_monitor_event_gating_regs;
	import mevg_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [9:0] wbAdr = 10'h000;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDatI = 32'h0;
	logic [31:0] wbDatO;
	logic wbAck;
	logic [7:0][11:0] adcReading = '0;
	logic [7:0] readingRead = 8'h00;
	logic [2:0][7:0] tempLow = {3{8'h80}};
	logic [2:0][7:0] tempHigh = {3{8'h7F}};
	logic [3:0][15:0] tachReading = '0;
	logic [3:0][15:0] tachMin = {4{16'hFFFF}};
	logic [2:0][7:0] pwmDuty = '0;
	logic [2:0] pwmFanDisabled = 3'h0;
	logic alertPinN;
	logic irq;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;
	mevg_regs uut (.clk(clk), .rstn(rstn), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .adcReading(adcReading),
		.readingRead(readingRead), .tempLowLimit(tempLow),
		.tempHighLimit(tempHigh), .tachReading(tachReading),
		.tachMinLimit(tachMin), .pwmDuty(pwmDuty),
		.pwmFanDisabled(pwmFanDisabled), .alertPinN(alertPinN),
		.irq(irq));
	always #5 clk = ~clk;
	task automatic summarize();
		$display("compares=%0d mismatches=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// The ceiling is far above the few hundred cycles the tests need.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d, output logic [31:0] q);
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= {idx, 2'b00};
		wbSel <= 4'hF;
		wbDatI <= {24'h0, d};
		// Ack is sampled at each edge; read data is taken at that edge.
		// Only the cycle ceiling ends a wait that never sees ack.
		do begin
			@(posedge clk);
		end while (wbAck !== 1'b1);
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, idx, d, q);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] q;
		xfer(1'b0, idx, 8'h00, q);
		check(q, {24'h0, e});
	endtask
	// Events take one cycle to status and one more to the pins.
	task automatic settle();
		repeat (4) @(posedge clk);
	endtask
	task automatic pin(input logic e);
		check({31'h0, alertPinN}, {31'h0, e});
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(IDX_FAN_EN, 8'h1E);
		rd(IDX_ASSOC, 8'hA4);
		rd(IDX_TEMP_EN, 8'h0E);
		rd(IDX_TEST_A, 8'h00);
		rd(IDX_TEST_B, 8'h4D);
		rd(IDX_TEST_C, 8'h4D);
		rd(IDX_CTRL, 8'h00);
		rd(8'h84, 8'h00);
		wr(8'h84, 8'hFF);
		wr(IDX_TEST_B, 8'h00);
		rd(IDX_TEST_B, 8'h4D);
		wr(IDX_FAN_EN, 8'hFE);
		rd(IDX_FAN_EN, 8'h1E);
		wr(IDX_TEMP_EN, 8'hF0);
		rd(IDX_TEMP_EN, 8'h00);
		wr(IDX_TEMP_EN, 8'h0E);
		$display("test registers done");
		// Tach 1 runs slow while its PWM is off.
		tachMin[0] <= 16'h0100;
		tachReading[0] <= 16'h0200;
		settle();
		rd(IDX_STATUS, 8'h00);
		pwmDuty[0] <= 8'h80;
		pwmFanDisabled[0] <= 1'b1;
		settle();
		rd(IDX_STATUS, 8'h00);
		// Reroute before re-enabling, or the event slips in early.
		wr(IDX_ASSOC, 8'hA7);
		pwmFanDisabled[0] <= 1'b0;
		settle();
		rd(IDX_STATUS, 8'h00);
		wr(IDX_ASSOC, 8'hA5);
		wr(IDX_FAN_EN, 8'h1C);
		pwmDuty[0] <= 8'h00;
		pwmDuty[1] <= 8'h40;
		settle();
		rd(IDX_STATUS, 8'h00);
		tachMin[0] <= 16'hFFFF;
		wr(IDX_FAN_EN, 8'h1E);
		settle();
		rd(IDX_STATUS, 8'h00);
		tachMin[0] <= 16'h0100;
		wr(IDX_CTRL, 8'h04);
		settle();
		rd(IDX_STATUS, 8'h01);
		pin(1'b1);
		wr(IDX_FAN_EN, 8'h1F);
		settle();
		pin(1'b0);
		wr(IDX_CTRL, 8'h00);
		settle();
		pin(1'b1);
		wr(IDX_MASK, 8'h01);
		settle();
		check({31'h0, irq}, 32'h1);
		tachReading[0] <= 16'h0000;
		wr(IDX_STATUS, 8'h01);
		settle();
		rd(IDX_STATUS, 8'h00);
		check({31'h0, irq}, 32'h0);
		$display("test fan events done");
		// Ambient reading above its high limit.
		tempHigh[0] <= 8'h10;
		adcReading[2] <= 12'h200;
		wr(IDX_CTRL, 8'h04);
		settle();
		rd(IDX_STATUS, 8'h10);
		pin(1'b1);
		wr(IDX_TEMP_EN, 8'h0F);
		settle();
		pin(1'b0);
		adcReading[2] <= 12'h000;
		wr(IDX_TEMP_EN, 8'h0D);
		wr(IDX_STATUS, 8'h10);
		adcReading[2] <= 12'h200;
		settle();
		rd(IDX_STATUS, 8'h00);
		pin(1'b1);
		$display("test thermal events done");
		adcReading[0] <= 12'h5A3;
		adcReading[1] <= 12'h7C9;
		adcReading[6] <= 12'h12E;
		adcReading[7] <= 12'h34B;
		@(posedge clk);
		readingRead <= 8'hC3;
		@(posedge clk);
		readingRead <= 8'h00;
		adcReading[0] <= 12'h000;
		rd(IDX_LOW_DIODES, 8'h93);
		rd(IDX_LOW_VCC, 8'hBE);
		rd(IDX_LOW_12V_AMBIENT, 8'h00);
		$display("test low bits done");
		wr(IDX_CTRL, 8'h01);
		wr(IDX_FAN_EN, 8'h00);
		wr(IDX_ASSOC, 8'h00);
		wr(IDX_TEMP_EN, 8'h00);
		wr(IDX_TEST_C, 8'h00);
		rd(IDX_FAN_EN, 8'h1F);
		rd(IDX_ASSOC, 8'hA5);
		rd(IDX_TEMP_EN, 8'h0D);
		rd(IDX_TEST_C, 8'h4D);
		wr(IDX_CTRL, 8'h80);
		repeat (2) @(posedge clk);
		rd(IDX_FAN_EN, 8'h1E);
		wr(IDX_TEST_C, 8'h12);
		rd(IDX_TEST_C, 8'h12);
		rd(IDX_LOW_DIODES, 8'h93);
		$display("test lock and soft reset done");
		summarize();
	end
endmodule
`default_nettype wire
